// ===== hw/abo_pkg.sv
// constants and types for the branch and arithmetic operation slice
// ----------------------------------------------------------------
// Behaviour
// RULE_01 - pc relative sum adds sign-extended immediate to bundle address
// RULE_02 - saturating add clamps the 32-bit signed sum instead of wrapping
// RULE_03 - packed halfword sum saturates each signed 16-bit lane separately
// RULE_04 - overflow test writes nonzero when the saturating add would clamp
// RULE_05 - bitwise and, and complement-first-then-and, register or immediate
// RULE_06 - logical and gives one when both operands nonzero; general or branch
// RULE_07 - quad byte average sums four bytes per lane plus rounding, shifts two
// RULE_08 - software waits one cycle for quad average and avoids link destination
// RULE_09 - restricted destinations never name the link register
// RULE_10 - pairwise byte average adds one if rounding nonzero, shifts one
// RULE_11 - conditional jumps add offset times four to bundle address on condition
// RULE_12 - jumps and jump-and-link sit in the first syllable of a bundle
// RULE_13 - trap always raises the illegal opcode exception
// RULE_14 - jump via link goes to link address and links the next bundle
// RULE_15 - software spaces link register writers before jump via link
// RULE_16 - leading zero count of the 32-bit source
// RULE_17 - equality compare with immediate writes a branch register
// RULE_18 - branch register consumed by jumps two cycles after compare
// RULE_19 - float add placed at even address, result read after two cycles
// RULE_20 - float add does single precision addition of two operands
// RULE_21 - no operation other than trap raises an exception
// ----------------------------------------------------------------
package abo_pkg;
	localparam int ABO_W        = 32;
	localparam int ABO_OFS_W    = 23;
	localparam int ABO_OFS_SHL  = 2;
	localparam int ABO_BUNDLE_B = 4;
	localparam logic [31:0] ABO_RST_WORD = 32'h0000_0000;
	localparam logic [3:0]  ABO_RST_BR   = 4'h0;
	localparam logic [3:0]  ABO_NEXT_INC = 4'h8;

	typedef enum logic [4:0] {
		ABO_OP_NONE    = 5'h00,
		ABO_OP_PCSUM   = 5'h01,
		ABO_OP_SATADD  = 5'h03,
		ABO_OP_HSATADD = 5'h02,
		ABO_OP_SATTEST = 5'h06,
		ABO_OP_AND     = 5'h07,
		ABO_OP_ANDC    = 5'h05,
		ABO_OP_LAND    = 5'h04,
		ABO_OP_AVG4    = 5'h0c,
		ABO_OP_AVG2    = 5'h0d,
		ABO_OP_JTRUE   = 5'h0f,
		ABO_OP_JFALSE  = 5'h0e,
		ABO_OP_TRAP    = 5'h0a,
		ABO_OP_JLINK   = 5'h0b,
		ABO_OP_CLZ     = 5'h09,
		ABO_OP_CMPEQ   = 5'h08,
		ABO_OP_FADD    = 5'h18
	} abo_op_e;

	typedef struct packed {
		logic [31:0] result;
		logic [3:0]  br_result;
		logic        res_valid;
		logic        br_valid;
		logic        jump_take;
		logic [31:0] jump_target;
		logic        link_we;
		logic [31:0] link_data;
		logic        trap;
	} abo_state_s;
endpackage

// ===== hw/abo_unit.sv
// execution slice for the branch and arithmetic operation run
`timescale 1ns/1ps
module abo_unit (
	input  wire logic           clk_sys,
	input  wire logic           rstn,
	input  wire logic           op_valid,
	input  wire abo_pkg::abo_op_e op_code,
	input  wire logic [31:0]    src1,
	input  wire logic [31:0]    src2,
	input  wire logic [31:0]    imm,
	input  wire logic           use_imm,
	input  wire logic [3:0]     bsrc1,
	input  wire logic [3:0]     bsrc2,
	input  wire logic           land_br_src,
	input  wire logic [3:0]     bcond,
	input  wire logic [22:0]    jump_ofs,
	input  wire logic [31:0]    current_bundle_address,
	input  wire logic [31:0]    next_bundle_address,
	input  wire logic [31:0]    link_value,
	output logic [31:0]         result,
	output logic                res_valid,
	output logic [3:0]          br_result,
	output logic                br_valid,
	output logic                jump_take,
	output logic [31:0]         jump_target,
	output logic                link_we,
	output logic [31:0]         link_data,
	output logic                illegal_opcode_trap
);
	import abo_pkg::*;

	abo_state_s st_reg;
	abo_state_s st_next;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [32:0] sum33(input logic [31:0] a, input logic [31:0] b);
		sum33 = {a[31], a} + {b[31], b};
	endfunction

	function automatic logic sat_ovf(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = sum33(a, b);
		sat_ovf = s[32] ^ s[31];
	endfunction

	function automatic logic [15:0] sat16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] ^ s[15])
			sat16 = s[16] ? 16'h8000 : 16'h7fff;
		else
			sat16 = s[15:0];
	endfunction

	function automatic logic [5:0] clz32(input logic [31:0] a);
		logic [5:0] n;
		logic       hit;
		n = 6'd32;
		hit = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (!hit && a[i]) begin
				n = 6'(31 - i);
				hit = 1'b1;
			end
		end
		clz32 = n;
	endfunction

	function automatic logic [15:0] avg4(input logic [31:0] a, input logic [31:0] b,
		input int lane, input logic [1:0] rnd);
		logic [9:0] s;
		s = {8'h00, rnd} + {2'b00, a[lane*16 +: 8]} + {2'b00, a[lane*16+8 +: 8]}
			+ {2'b00, b[lane*16 +: 8]} + {2'b00, b[lane*16+8 +: 8]};
		avg4 = {8'h00, s[9:2]};
	endfunction

	function automatic logic [31:0] fadd32(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] x;
		logic [31:0] y;
		logic [26:0] mx;
		logic [26:0] my;
		logic [27:0] m;
		logic [24:0] r;
		logic [9:0]  e;
		logic [7:0]  d;
		x = (a[30:0] >= b[30:0]) ? a : b;
		y = (a[30:0] >= b[30:0]) ? b : a;
		mx = {1'b1, x[22:0], 3'b000};
		my = (y[30:23] == 8'h00) ? 27'h0 : {1'b1, y[22:0], 3'b000};
		e = {2'b00, x[30:23]};
		d = x[30:23] - y[30:23];
		for (int i = 0; i < 27; i++) begin
			if (i < int'(d))
				my = {1'b0, my[26:2], my[1] | my[0]};
		end
		if (x[31] ^ y[31])
			m = {1'b0, mx} - {1'b0, my};
		else
			m = {1'b0, mx} + {1'b0, my};
		if (m[27]) begin
			m = {1'b0, m[27:2], m[1] | m[0]};
			e = e + 10'd1;
		end
		for (int i = 0; i < 26; i++) begin
			if (!m[26] && m != 28'h0) begin
				m = {m[26:0], 1'b0};
				e = e - 10'd1;
			end
		end
		r = {1'b0, m[26:3]} + {24'h0, m[2] & (m[3] | m[1] | m[0])};
		e = e + {9'h0, r[24]};
		if (x[30:23] == 8'hff)
			fadd32 = (y[30:23] == 8'hff && x[31] != y[31] && x[22:0] == 23'h0) ?
				32'h7fc0_0000 : x;
		else if (x[30:23] == 8'h00)
			fadd32 = {x[31] & y[31], 31'h0};
		else if (m == 28'h0)
			fadd32 = 32'h0;
		else if (e[9] || e == 10'h000)
			fadd32 = {x[31], 31'h0};
		else if (e >= 10'd255)
			fadd32 = {x[31], 8'hff, 23'h0};
		else
			fadd32 = {x[31], e[7:0], r[24] ? r[23:1] : r[22:0]};
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] opnd2;
		logic [32:0] s33;
		logic [8:0]  bsum;
		logic        a_nz;
		logic        b_nz;
		opnd2 = use_imm ? imm : src2;
		s33 = sum33(src1, src2);
		bsum = 9'h000;
		a_nz = 1'b0;
		b_nz = 1'b0;
		st_next = st_reg;
		st_next.res_valid = 1'b0;
		st_next.br_valid = 1'b0;
		st_next.jump_take = 1'b0;
		st_next.link_we = 1'b0;
		st_next.trap = 1'b0; // [RULE_21]
		if (op_valid) begin
			unique case (op_code)
				ABO_OP_PCSUM: begin
					st_next.result = current_bundle_address + imm; // [RULE_01]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_SATADD: begin
					if (s33[32] ^ s33[31]) // [RULE_02]
						st_next.result = s33[32] ? 32'h8000_0000 : 32'h7fff_ffff;
					else
						st_next.result = s33[31:0];
					st_next.res_valid = 1'b1;
				end
				ABO_OP_HSATADD: begin
					st_next.result = {sat16(src1[31:16], src2[31:16]),
						sat16(src1[15:0], src2[15:0])}; // [RULE_03]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_SATTEST: begin
					st_next.result = {31'h0, sat_ovf(src1, src2)}; // [RULE_04]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_AND: begin
					st_next.result = src1 & opnd2; // [RULE_05]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_ANDC: begin
					st_next.result = ~src1 & opnd2; // [RULE_05]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_LAND: begin
					a_nz = land_br_src ? (bsrc1 != 4'h0) : (src1 != 32'h0);
					b_nz = land_br_src ? (bsrc2 != 4'h0) : (src2 != 32'h0);
					st_next.result = {31'h0, a_nz & b_nz}; // [RULE_06]
					st_next.br_result = {3'h0, a_nz & b_nz};
					st_next.res_valid = 1'b1;
					st_next.br_valid = 1'b1;
				end
				ABO_OP_AVG4: begin
					st_next.result = {avg4(src1, src2, 1, bcond[1:0]),
						avg4(src1, src2, 0, bcond[1:0])}; // [RULE_07]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_AVG2: begin
					for (int j = 0; j < 4; j++) begin
						bsum = {1'b0, src1[j*8 +: 8]} + {1'b0, src2[j*8 +: 8]}
							+ {8'h00, bcond != 4'h0};
						st_next.result[j*8 +: 8] = bsum[8:1]; // [RULE_10]
					end
					st_next.res_valid = 1'b1;
				end
				ABO_OP_JTRUE, ABO_OP_JFALSE: begin
					st_next.jump_target = current_bundle_address
						+ {{7{jump_ofs[22]}}, jump_ofs, 2'b00}; // [RULE_11]
					st_next.jump_take = (op_code == ABO_OP_JTRUE) ?
						(bcond != 4'h0) : (bcond == 4'h0); // [RULE_11]
				end
				ABO_OP_TRAP: st_next.trap = 1'b1; // [RULE_13]
				ABO_OP_JLINK: begin
					st_next.jump_target = link_value; // [RULE_14]
					st_next.jump_take = 1'b1;
					st_next.link_data = next_bundle_address;
					st_next.link_we = 1'b1;
				end
				ABO_OP_CLZ: begin
					st_next.result = {26'h0, clz32(src1)}; // [RULE_16]
					st_next.res_valid = 1'b1;
				end
				ABO_OP_CMPEQ: begin
					st_next.br_result = {3'h0, src1 == imm}; // [RULE_17]
					st_next.br_valid = 1'b1;
				end
				ABO_OP_FADD: begin
					st_next.result = fadd32(src1, src2); // [RULE_20]
					st_next.res_valid = 1'b1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign result = st_reg.result;
	assign res_valid = st_reg.res_valid;
	assign br_result = st_reg.br_result;
	assign br_valid = st_reg.br_valid;
	assign jump_take = st_reg.jump_take;
	assign jump_target = st_reg.jump_target;
	assign link_we = st_reg.link_we;
	assign link_data = st_reg.link_data;
	assign illegal_opcode_trap = st_reg.trap;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	pc_sum_a: assert property (op_valid && op_code == ABO_OP_PCSUM |=> // [RULE_01]
		res_valid && result == $past(current_bundle_address) + $past(imm))
		else $error("pc sum wrong");
	sat_clamp_a: assert property (op_valid && op_code == ABO_OP_SATADD // [RULE_02]
		&& sat_ovf(src1, src2) && !src1[31] |=> result == 32'h7fff_ffff)
		else $error("saturating add not clamped");
	half_sat_a: assert property (op_valid && op_code == ABO_OP_HSATADD // [RULE_03]
		&& src1[15:0] == 16'h7fff && src2[15:0] == 16'h0001 |=> result[15:0] == 16'h7fff)
		else $error("lane not saturated");
	sat_test_a: assert property (op_valid && op_code == ABO_OP_SATTEST |=> // [RULE_04]
		result[0] == sat_ovf($past(src1), $past(src2)))
		else $error("overflow test wrong");
	andc_a: assert property (op_valid && op_code == ABO_OP_ANDC |=> // [RULE_05]
		(result & $past(src1)) == 32'h0)
		else $error("andc wrong");
	land_a: assert property (op_valid && op_code == ABO_OP_LAND && !land_br_src // [RULE_06]
		&& src1 == 32'h0 |=> result == 32'h0 && br_result == 4'h0)
		else $error("logical and wrong");
	jump_false_a: assert property (op_valid && op_code == ABO_OP_JFALSE // [RULE_11]
		|=> jump_take == ($past(bcond) == 4'h0))
		else $error("branch false condition wrong");
	trap_only_a: assert property (illegal_opcode_trap |-> // [RULE_21]
		$past(op_valid) && $past(op_code) == ABO_OP_TRAP)
		else $error("spurious trap");
	link_swap_a: assert property (op_valid && op_code == ABO_OP_JLINK |=> // [RULE_14]
		jump_target == $past(link_value) && link_we && link_data == $past(next_bundle_address)
		##1 link_we == ($past(op_valid) && $past(op_code) == ABO_OP_JLINK))
		else $error("jump via link wrong");
	clz_zero_a: assert property (op_valid && op_code == ABO_OP_CLZ && src1 == 32'h0 // [RULE_16]
		|=> result == 32'd32)
		else $error("clz of zero wrong");
	cmpeq_a: assert property (op_valid && op_code == ABO_OP_CMPEQ |=> // [RULE_17]
		br_valid && br_result[0] == ($past(src1) == $past(imm)))
		else $error("compare wrong");
	avg2_a: assert property (op_valid && op_code == ABO_OP_AVG2 && bcond == 4'h0 // [RULE_10]
		&& src1[7:0] == 8'h01 && src2[7:0] == 8'h00 |=> result[7:0] == 8'h00)
		else $error("pairwise average rounding wrong");
	fadd_valid_a: assert property (op_valid && op_code == ABO_OP_FADD |=> res_valid) // [RULE_20]
		else $error("float add gave no result");

	jump_c: cover property (op_valid && op_code == ABO_OP_JTRUE ##1 jump_take);
	link_c: cover property (op_valid && op_code == ABO_OP_JLINK ##1 link_we);
	trap_c: cover property (illegal_opcode_trap);
	sat_c: cover property (op_valid && op_code == ABO_OP_SATADD && sat_ovf(src1, src2));
	fadd_c: cover property (op_valid && op_code == ABO_OP_FADD ##1 res_valid);
endmodule

// ===== tb/tb.sv
// self-checking bench for the branch and arithmetic operation slice
`timescale 1ns/1ps
module tb;
	import abo_pkg::*;
	logic        clk_sys = 0;
	logic        rstn = 0;
	logic        op_valid = 0, use_imm = 0, land_br_src = 0;
	abo_op_e     op_code = ABO_OP_NONE;
	logic [31:0] src1 = 0, src2 = 0, imm = 0, cur = 0, nxt = 0, lnk = 0;
	logic [3:0]  bsrc1 = 0, bsrc2 = 0, bcond = 0;
	logic [22:0] jump_ofs = 0;
	logic [31:0] result, jump_target, link_data;
	logic [3:0]  br_result;
	logic        res_valid, br_valid, jump_take, link_we, illegal_opcode_trap;
	int          errors = 0, tests_run = 0;
	always #2 clk_sys = ~clk_sys;
	abo_unit dut (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
		.src1(src1), .src2(src2), .imm(imm), .use_imm(use_imm), .bsrc1(bsrc1), .bsrc2(bsrc2),
		.land_br_src(land_br_src), .bcond(bcond), .jump_ofs(jump_ofs),
		.current_bundle_address(cur), .next_bundle_address(nxt), .link_value(lnk),
		.result(result), .res_valid(res_valid), .br_result(br_result), .br_valid(br_valid),
		.jump_take(jump_take), .jump_target(jump_target), .link_we(link_we),
		.link_data(link_data), .illegal_opcode_trap(illegal_opcode_trap));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic side(input logic [22:0] o, input logic [3:0] b1, b2, input logic lb);
		@(posedge clk_sys);
		jump_ofs <= o;
		bsrc1 <= b1;
		bsrc2 <= b2;
		land_br_src <= lb;
	endtask
	task automatic issue(input abo_op_e op, input logic [31:0] a, b, i, input logic u,
		input logic [3:0] bc);
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op_code <= op;
		src1 <= a;
		src2 <= b;
		imm <= i;
		use_imm <= u;
		bcond <= bc;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		#1;
		chk("trap", {31'h0, op == ABO_OP_TRAP}, {31'h0, illegal_opcode_trap});
	endtask
	task automatic opr(input abo_op_e op, input logic [31:0] a, b, i, input logic u,
		input logic [3:0] bc, input logic [31:0] e);
		issue(op, a, b, i, u, bc);
		chk("result", e, result);
		chk("res_valid", 32'h1, {31'h0, res_valid});
	endtask
	task automatic jmp(input abo_op_e op, input logic [22:0] o, input logic [3:0] bc,
		input logic t, input logic [31:0] e);
		side(o, 4'h0, 4'h0, 1'b0);
		issue(op, 32'h0, 32'h0, 32'h0, 1'b0, bc);
		chk("jump_take", {31'h0, t}, {31'h0, jump_take});
		if (t)
			chk("jump_target", e, jump_target);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_arith;
		opr(ABO_OP_PCSUM, 32'h0, 32'h0, 32'hffff_fff0, 1'b0, 4'h0, 32'h0fff_fff0);
		opr(ABO_OP_SATADD, 32'h7fff_ffff, 32'h1, 32'h0, 1'b0, 4'h0, 32'h7fff_ffff);
		@(posedge clk_sys);
		#1;
		chk("res_pulse", 32'h0, {31'h0, res_valid});
		opr(ABO_OP_SATADD, 32'h8000_0000, 32'hffff_ffff, 32'h0, 1'b0, 4'h0, 32'h8000_0000);
		opr(ABO_OP_SATADD, 32'h5, 32'hffff_fffd, 32'h0, 1'b0, 4'h0, 32'h2);
		opr(ABO_OP_HSATADD, 32'h7fff_8000, 32'h0001_ffff, 32'h0, 1'b0, 4'h0, 32'h7fff_8000);
		opr(ABO_OP_HSATADD, 32'h0002_fffd, 32'h0001_0004, 32'h0, 1'b0, 4'h0, 32'h0003_0001);
		opr(ABO_OP_HSATADD, 32'h8000_7fff, 32'hffff_0001, 32'h0, 1'b0, 4'h0, 32'h8000_7fff);
		issue(ABO_OP_SATTEST, 32'h7fff_ffff, 32'h1, 32'h0, 1'b0, 4'h0);
		chk("ovf_set", 32'h1, {31'h0, |result});
		issue(ABO_OP_SATTEST, 32'h1, 32'h2, 32'h0, 1'b0, 4'h0);
		chk("ovf_clear", 32'h0, result);
	endtask
	task automatic t_logic;
		opr(ABO_OP_AND, 32'hf0f0_ff00, 32'h0ff0_0ff0, 32'h0, 1'b0, 4'h0, 32'h00f0_0f00);
		opr(ABO_OP_AND, 32'hf0f0_ff00, 32'h0, 32'hffff_fff0, 1'b1, 4'h0, 32'hf0f0_ff00);
		opr(ABO_OP_ANDC, 32'hf0f0_ff00, 32'h0ff0_0ff0, 32'h0, 1'b0, 4'h0, 32'h0f00_00f0);
		opr(ABO_OP_ANDC, 32'hf0f0_ff00, 32'h0, 32'hffff_fff0, 1'b1, 4'h0, 32'h0f0f_00f0);
		opr(ABO_OP_LAND, 32'h5, 32'h0, 32'h0, 1'b0, 4'h0, 32'h0);
		opr(ABO_OP_LAND, 32'h5, 32'h8000_0000, 32'h0, 1'b0, 4'h0, 32'h1);
		opr(ABO_OP_LAND, 32'h0, 32'h5, 32'h0, 1'b0, 4'h0, 32'h0);
		side(23'h0, 4'h2, 4'h8, 1'b1);
		opr(ABO_OP_LAND, 32'h0, 32'h0, 32'h0, 1'b0, 4'h0, 32'h1);
		chk("land_br", 32'h1, {28'h0, br_result});
		side(23'h0, 4'h2, 4'h0, 1'b1);
		opr(ABO_OP_LAND, 32'h5, 32'h5, 32'h0, 1'b0, 4'h0, 32'h0);
	endtask
	task automatic t_avg;
		opr(ABO_OP_AVG4, 32'h0403_0201, 32'h0807_0605, 32'h0, 1'b0, 4'h0, 32'h0005_0003);
		@(posedge clk_sys);
		#1;
		chk("avg4_hold", 32'h0005_0003, result);
		opr(ABO_OP_AVG4, 32'h0403_0201, 32'h0807_0605, 32'h0, 1'b0, 4'hf, 32'h0006_0004);
		opr(ABO_OP_AVG4, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 1'b0, 4'h3, 32'h00ff_00ff);
		opr(ABO_OP_AVG2, 32'h01ff_0003, 32'h02ff_0004, 32'h0, 1'b0, 4'h8, 32'h02ff_0004);
		opr(ABO_OP_AVG2, 32'h01ff_0003, 32'h02ff_0004, 32'h0, 1'b0, 4'h0, 32'h01ff_0003);
		opr(ABO_OP_AVG2, 32'h0000_0001, 32'h0, 32'h0, 1'b0, 4'h0, 32'h0000_0000);
	endtask
	task automatic t_flow;
		jmp(ABO_OP_JTRUE, 23'h7f_fffe, 4'h1, 1'b1, 32'h0fff_fff8);
		jmp(ABO_OP_JTRUE, 23'h00_0003, 4'h0, 1'b0, 32'h0);
		jmp(ABO_OP_JFALSE, 23'h00_0003, 4'h0, 1'b1, 32'h1000_000c);
		jmp(ABO_OP_JFALSE, 23'h00_0003, 4'h4, 1'b0, 32'h0);
		issue(ABO_OP_TRAP, 32'h0, 32'h0, 32'h0, 1'b0, 4'h0);
		jmp(ABO_OP_JLINK, 23'h0, 4'h0, 1'b1, 32'h2000_0040);
		chk("link_we", 32'h1, {31'h0, link_we});
		chk("link_data", 32'h1000_0010, link_data);
	endtask
	task automatic t_count;
		logic [31:0] v [4] = '{32'h0, 32'h1, 32'h8000_0000, 32'h0001_0000};
		logic [31:0] n [4] = '{32'd32, 32'd31, 32'd0, 32'd15};
		for (int k = 0; k < 4; k++) begin
			opr(ABO_OP_CLZ, v[k], 32'h0, 32'h0, 1'b0, 4'h0, n[k]);
		end
		issue(ABO_OP_CMPEQ, 32'hffff_fff6, 32'h0, 32'hffff_fff6, 1'b1, 4'h0);
		chk("eq_true", 32'h11, {27'h0, br_valid, br_result});
		issue(ABO_OP_CMPEQ, 32'hffff_fff6, 32'h0, 32'h0000_fff6, 1'b1, 4'h0);
		chk("eq_false", 32'h10, {27'h0, br_valid, br_result});
		issue(ABO_OP_FADD, 32'h3f80_0000, 32'h3f80_0000, 32'h0, 1'b0, 4'h0);
		chk("fadd_valid", 32'h1, {31'h0, res_valid});
		@(posedge clk_sys);
		#1;
		chk("fadd_sum", 32'h4000_0000, result);
		opr(ABO_OP_FADD, 32'hbf80_0000, 32'h3fc0_0000, 32'h0, 1'b0, 4'h0, 32'h3f00_0000);
		issue(ABO_OP_NONE, 32'h3f80_0000, 32'h3f80_0000, 32'h0, 1'b0, 4'h0);
		chk("idle_valids", 32'h0, {30'h0, res_valid, br_valid});
	endtask
	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#40000;
		errors++;
		tally_and_finish();
	end
	initial begin
		cur = 32'h1000_0000;
		nxt = 32'h1000_0010;
		lnk = 32'h2000_0040;
		repeat (6) @(posedge clk_sys);
		chk("reset_out", 32'h0, {27'h0, res_valid, br_valid, jump_take, link_we,
			illegal_opcode_trap});
		rstn <= 1'b1;
		t_arith();
		t_logic();
		t_avg();
		t_flow();
		t_count();
		tally_and_finish();
	end
endmodule
